/* File: tcd_pkg.sv */
// Package for the translation control decode block
package tcd_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [3:0] TCD_OFF_CTRL = 4'h0;
    localparam logic [3:0] TCD_OFF_CFG = 4'h4;
    localparam logic [3:0] TCD_OFF_STAT = 4'h8;
    localparam logic [31:0] TCD_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] TCD_CFG_RESET = 32'h0000_0000;
    // Bank configuration bit positions
    localparam int TCD_CFG_WIDE = 0;
    localparam int TCD_CFG_HYP = 1;
    localparam int TCD_CFG_MON = 2;
    localparam int TCD_CFG_SEC = 3;
    localparam int TCD_CFG_S2 = 4;
    localparam int TCD_CFG_STAGE1 = 5;
    localparam int TCD_CFG_W = 6;
    // Translation control field positions
    localparam int TCD_EAE_BIT = 31;
    localparam int TCD_NS1_BIT = 30;
    localparam int TCD_WO1_BIT = 23;
    localparam int TCD_ASEL_BIT = 22;
    localparam int TCD_NS0_BIT = 14;
    localparam int TCD_WO0_BIT = 7;
    localparam int TCD_SWO1_BIT = 5;
    localparam int TCD_SWO0_BIT = 4;
    localparam int TCD_SH1_LO = 28;
    localparam int TCD_OC1_LO = 26;
    localparam int TCD_IC1_LO = 24;
    localparam int TCD_SH0_LO = 12;
    localparam int TCD_OC0_LO = 10;
    localparam int TCD_IC0_LO = 8;
    localparam int TCD_G1_LO = 30;
    localparam int TCD_G0_LO = 14;
    localparam int TCD_SZ1_LO = 16;
    localparam int TCD_SZ0_LO = 0;
    localparam int TCD_SZL_W = 3;
    localparam int TCD_SZW_W = 6;
    // Long layout reserved bits 21:19, 15, 6:3 read as zero
    localparam logic [31:0] TCD_LONG_MASK = 32'hffc7_7f87;
    // Granule codes (normalised)
    localparam logic [1:0] TCD_GR_4K = 2'h0;
    localparam logic [1:0] TCD_GR_16K = 2'h1;
    localparam logic [1:0] TCD_GR_64K = 2'h2;
    // Region-one granule encoding
    localparam logic [1:0] TCD_G1_16K = 2'h1;
    localparam logic [1:0] TCD_G1_4K = 2'h2;
    localparam logic [1:0] TCD_G1_64K = 2'h3;
    // Region-zero granule encoding
    localparam logic [1:0] TCD_G0_4K = 2'h0;
    localparam logic [1:0] TCD_G0_64K = 2'h1;
    localparam logic [1:0] TCD_G0_16K = 2'h2;

    // Shareability decode
    typedef enum logic [1:0] {
        TCD_SH_NONE = 2'h0,
        TCD_SH_UNPRED = 2'h1,
        TCD_SH_OUTER = 2'h2,
        TCD_SH_INNER = 2'h3
    } tcd_share_e;

    // Cacheability decode
    typedef enum logic [1:0] {
        TCD_C_NC = 2'h0,
        TCD_C_WBWA = 2'h1,
        TCD_C_WT = 2'h2,
        TCD_C_WBNA = 2'h3
    } tcd_cache_e;

    // Walk attributes for one region
    typedef struct packed {
        logic walk_off;
        logic nonsecure;
        tcd_share_e share;
        tcd_cache_e outer;
        tcd_cache_e inner;
        logic [5:0] size_offset;
        logic [1:0] granule;
    } tcd_region_s;

    // Decoded controls seen by walker and TLB
    typedef struct packed {
        tcd_region_s region_zero;
        tcd_region_s region_one;
        logic asid_source_select;
        logic extended_address_enable;
        logic wide_address_select;
    } tcd_ctrl_s;

    // Bus access state
    typedef enum logic [2:0] {
        TCD_ST_IDLE = 3'b001,
        TCD_ST_ACK = 3'b010,
        TCD_ST_HOLD = 3'b100
    } tcd_bus_e;
endpackage : tcd_pkg

/* File: tcd_decode.sv */
// Translation control register and its decode for the walker and TLB
`timescale 1ns/100ps
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module tcd_decode
    import tcd_pkg::*;
#(
    parameter logic [1:0] FALLBACK_GRANULE = TCD_GR_4K,
    parameter bit READ_CHOSEN = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // Walk request from the TLB on a miss
    input wire logic miss_valid,
    input wire logic miss_region_one,
    output logic walk_start,
    output logic walk_fault,
    // Decoded controls
    output tcd_ctrl_s ctrl
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        tcd_bus_e bus;
        logic [31:0] tcr;
        logic [TCD_CFG_W-1:0] cfg;
        logic [31:0] rdata;
        logic [1:0] resp;
        tcd_ctrl_s ctrl;
        logic walk_start;
        logic walk_fault;
    } tcd_state_s;

    tcd_state_s st;
    tcd_state_s next_st;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
        input logic [31:0] new_v, input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Reserved granule falls back to an implemented size
    function automatic logic [1:0] gran_one(input logic [1:0] code);
        unique case (code)
            TCD_G1_16K: return TCD_GR_16K;
            TCD_G1_4K: return TCD_GR_4K;
            TCD_G1_64K: return TCD_GR_64K;
            default: return FALLBACK_GRANULE;
        endcase
    endfunction

    function automatic logic [1:0] gran_zero(input logic [1:0] code);
        unique case (code)
            TCD_G0_4K: return TCD_GR_4K;
            TCD_G0_64K: return TCD_GR_64K;
            TCD_G0_16K: return TCD_GR_16K;
            default: return FALLBACK_GRANULE;
        endcase
    endfunction

    function automatic logic [1:0] enc_one(input logic [1:0] g);
        return (g == TCD_GR_16K) ? TCD_G1_16K : ((g == TCD_GR_64K) ? TCD_G1_64K : TCD_G1_4K);
    endfunction

    function automatic logic [1:0] enc_zero(input logic [1:0] g);
        return (g == TCD_GR_16K) ? TCD_G0_16K : ((g == TCD_GR_64K) ? TCD_G0_64K : TCD_G0_4K);
    endfunction

    // ---------------------------------------------------------------
    // Decode of the stored register, combinational
    // ---------------------------------------------------------------
    logic wide;
    logic eff_eae;
    logic hyp;
    logic mon;
    logic sec;
    logic s1_plain;
    tcd_ctrl_s dec;
    logic [31:0] tcr_view;

    always_comb begin
        wide = st.cfg[TCD_CFG_WIDE];
        hyp = st.cfg[TCD_CFG_HYP];
        mon = st.cfg[TCD_CFG_MON];
        sec = st.cfg[TCD_CFG_SEC];
        s1_plain = st.cfg[TCD_CFG_STAGE1] && !hyp && !mon;
        // Effective extension enable
        eff_eae = st.tcr[TCD_EAE_BIT] || st.cfg[TCD_CFG_S2] || wide || hyp;
        dec = '0;
        dec.wide_address_select = wide;
        dec.extended_address_enable = eff_eae;
        dec.asid_source_select = eff_eae && st.tcr[TCD_ASEL_BIT];
        // Hypervisor banks have one region; walk-off bits are ignored there
        if (eff_eae && !hyp) begin
            dec.region_one.walk_off = st.tcr[TCD_WO1_BIT];
            dec.region_zero.walk_off = st.tcr[TCD_WO0_BIT];
        end else if (!eff_eae) begin
            dec.region_one.walk_off = st.tcr[TCD_SWO1_BIT];
            dec.region_zero.walk_off = st.tcr[TCD_SWO0_BIT];
        end
        // Non-secure walk attribute only honoured in secure banks
        dec.region_zero.nonsecure = sec && st.tcr[TCD_NS0_BIT];
        dec.region_one.nonsecure = sec && !wide && st.tcr[TCD_NS1_BIT];
        if (eff_eae) begin
            dec.region_zero.share = tcd_share_e'(st.tcr[TCD_SH0_LO +: 2]);
            dec.region_zero.outer = tcd_cache_e'(st.tcr[TCD_OC0_LO +: 2]);
            dec.region_zero.inner = tcd_cache_e'(st.tcr[TCD_IC0_LO +: 2]);
            dec.region_one.share = tcd_share_e'(st.tcr[TCD_SH1_LO +: 2]);
            dec.region_one.outer = tcd_cache_e'(st.tcr[TCD_OC1_LO +: 2]);
            dec.region_one.inner = tcd_cache_e'(st.tcr[TCD_IC1_LO +: 2]);
        end
        if (wide) begin
            dec.region_one.size_offset = st.tcr[TCD_SZ1_LO +: TCD_SZW_W];
            dec.region_zero.size_offset = st.tcr[TCD_SZ0_LO +: TCD_SZW_W];
            dec.region_zero.granule = gran_zero(st.tcr[TCD_G0_LO +: 2]);
            dec.region_one.granule = s1_plain ? gran_one(st.tcr[TCD_G1_LO +: 2])
                : FALLBACK_GRANULE;
        end else begin
            dec.region_one.size_offset = {3'h0, st.tcr[TCD_SZ1_LO +: TCD_SZL_W]};
            dec.region_zero.size_offset = {3'h0, st.tcr[TCD_SZ0_LO +: TCD_SZL_W]};
            dec.region_zero.granule = TCD_GR_4K;
            dec.region_one.granule = TCD_GR_4K;
        end
        // Readback view; long layout reserved bits read zero
        tcr_view = st.tcr;
        if (!wide && eff_eae) begin
            tcr_view = st.tcr & TCD_LONG_MASK;
        end
        if (wide && READ_CHOSEN) begin
            tcr_view[TCD_G0_LO +: 2] = enc_zero(dec.region_zero.granule);
            if (s1_plain) begin
                tcr_view[TCD_G1_LO +: 2] = enc_one(dec.region_one.granule);
            end
        end
    end

    // ---------------------------------------------------------------
    // Bus access and walk gating
    // ---------------------------------------------------------------
    logic bus_req;
    logic [31:0] cfg_merged;

    always_comb begin
        next_st = st;
        bus_req = avs_read || avs_write;
        cfg_merged = merge_bytes({{(32-TCD_CFG_W){1'b0}}, st.cfg}, avs_writedata,
            avs_byteenable);
        next_st.walk_start = 1'b0;
        next_st.walk_fault = 1'b0;
        // Controls track the register one cycle late, so a write reaches ctrl one cycle after it reaches the register
        next_st.ctrl = dec;
        unique case (st.bus)
            TCD_ST_IDLE: begin
                if (bus_req) begin
                    next_st.bus = TCD_ST_ACK;
                    next_st.resp = 2'h0;
                    next_st.rdata = 32'h0;
                    if (avs_write) begin
                        // Only the response is fixed here; the data lands in ACK
                        if (avs_address != TCD_OFF_CTRL && avs_address != TCD_OFF_CFG
                                && avs_address != TCD_OFF_STAT) begin
                            next_st.resp = 2'h3;
                        end
                    end else begin
                        unique case (avs_address)
                            TCD_OFF_CTRL: next_st.rdata = tcr_view;
                            TCD_OFF_CFG: next_st.rdata = {{(32-TCD_CFG_W){1'b0}}, st.cfg};
                            TCD_OFF_STAT: next_st.rdata = {29'h0, eff_eae,
                                st.ctrl.region_one.walk_off, st.ctrl.region_zero.walk_off};
                            default: next_st.resp = 2'h3;
                        endcase
                    end
                end
            end
            // Write lands at the edge that sees waitrequest low, never earlier
            TCD_ST_ACK: begin
                next_st.bus = TCD_ST_HOLD;
                if (avs_write && avs_address == TCD_OFF_CTRL) begin
                    next_st.tcr = merge_bytes(st.tcr, avs_writedata, avs_byteenable);
                end else if (avs_write && avs_address == TCD_OFF_CFG) begin
                    next_st.cfg = cfg_merged[TCD_CFG_W-1:0];
                end
            end
            TCD_ST_HOLD: next_st.bus = TCD_ST_IDLE;
            default: next_st.bus = TCD_ST_IDLE;
        endcase
        // Miss handling: walk or immediate level-1 section fault
        if (miss_valid) begin
            if (miss_region_one ? st.ctrl.region_one.walk_off
                    : st.ctrl.region_zero.walk_off) begin
                next_st.walk_fault = 1'b1;
            end else begin
                next_st.walk_start = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '{bus: TCD_ST_IDLE, tcr: TCD_CTRL_RESET, cfg: '0, rdata: '0,
                resp: '0, ctrl: '0, walk_start: 1'b0, walk_fault: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // Waitrequest drops in the ACK cycle: three cycles per access, counting the HOLD turnaround
    assign avs_waitrequest = (st.bus != TCD_ST_ACK);
    assign avs_readdata = st.rdata;
    assign avs_response = st.resp;
    assign walk_start = st.walk_start;
    assign walk_fault = st.walk_fault;
    assign ctrl = st.ctrl;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_fault_one;
        @(posedge ref_clk) disable iff (rst)
        miss_valid && miss_region_one && ctrl.region_one.walk_off |=> walk_fault && !walk_start;
    endproperty
    a_fault_one: assert property (p_fault_one) else $error("region one walk not blocked");

    property p_walk_zero;
        @(posedge ref_clk) disable iff (rst)
        miss_valid && !miss_region_one |=> walk_fault == $past(ctrl.region_zero.walk_off);
    endproperty
    a_walk_zero: assert property (p_walk_zero) else $error("region zero walk gate wrong");

    property p_hyp_nowalkoff;
        @(posedge ref_clk) disable iff (rst)
        st.cfg[TCD_CFG_HYP] |=> !ctrl.region_zero.walk_off && !ctrl.region_one.walk_off;
    endproperty
    a_hyp_nowalkoff: assert property (p_hyp_nowalkoff) else $error("hyp walk-off set");

    property p_asid;
        @(posedge ref_clk) disable iff (rst)
        (st.tcr[TCD_EAE_BIT] || st.cfg[TCD_CFG_WIDE])
        |=> ctrl.asid_source_select == $past(st.tcr[TCD_ASEL_BIT]);
    endproperty
    a_asid: assert property (p_asid) else $error("asid select mismatch");

    property p_ns;
        @(posedge ref_clk) disable iff (rst)
        !st.cfg[TCD_CFG_SEC] |=> !ctrl.region_zero.nonsecure;
    endproperty
    a_ns: assert property (p_ns) else $error("nonsecure outside secure bank");

    property p_size_wide;
        @(posedge ref_clk) disable iff (rst)
        wide |=> ctrl.region_one.size_offset == $past(st.tcr[21:16]);
    endproperty
    a_size_wide: assert property (p_size_wide) else $error("wide size offset wrong");

    property p_eae;
        @(posedge ref_clk) disable iff (rst)
        (wide || hyp) |=> ctrl.extended_address_enable;
    endproperty
    a_eae: assert property (p_eae) else $error("effective extension missing");

    property p_write_lat;
        @(posedge ref_clk) disable iff (rst)
        avs_write && !avs_waitrequest && avs_address == TCD_OFF_CTRL && avs_byteenable == 4'hf
        |=> st.tcr == $past(avs_writedata);
    endproperty
    a_write_lat: assert property (p_write_lat) else $error("write lost");

    property p_share_zero;
        @(posedge ref_clk) disable iff (rst)
        eff_eae |=> ctrl.region_zero.share == $past(st.tcr[13:12]);
    endproperty
    a_share_zero: assert property (p_share_zero) else $error("share decode wrong");
endmodule // tcd_decode

/* File: tb_top.sv */
// Self-checking bench for the translation control decode block
`timescale 1ns/100ps
module tb_top
    import tcd_pkg::*;
();
    // ---------------------------------------------------------------
    // Signals and scoreboard queues
    // ---------------------------------------------------------------
    typedef struct {
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0] r;
    } tcd_exp_rd_s;
    localparam logic [1:0] FB = TCD_GR_4K;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    logic miss_valid = 1'b0;
    logic miss_region_one = 1'b0;
    logic walk_start;
    logic walk_fault;
    tcd_ctrl_s ctrl;
    logic want_ctrl = 1'b0;
    int error_cnt = 0;
    int compares = 0;
    tcd_exp_rd_s rd_q[$];
    logic [1:0] walk_q[$];
    tcd_ctrl_s ce_q[$];
    tcd_ctrl_s cm_q[$];

    // Free-running 250 MHz clock
    always #2 ref_clk = ~ref_clk;

    tcd_decode #(.FALLBACK_GRANULE(FB), .READ_CHOSEN(1'b0)) u_tcd_decode (
        .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .miss_valid(miss_valid), .miss_region_one(miss_region_one),
        .walk_start(walk_start), .walk_fault(walk_fault), .ctrl(ctrl)
    );

    // ---------------------------------------------------------------
    // Reference decode
    // ---------------------------------------------------------------
    // Fields left open by the layout (short attributes, wide non-secure) stay masked out of the compare
    function automatic void model(input logic [31:0] t, input logic [5:0] c,
        output tcd_ctrl_s e, output tcd_ctrl_s m, output logic [31:0] rb,
        output logic [31:0] rbm);
        logic eae;
        eae = t[31] | c[4] | c[0] | c[1];
        e = '0;
        m = '0;
        rb = 32'h0;
        rbm = 32'h0;
        e.extended_address_enable = eae;
        e.wide_address_select = c[0];
        m.extended_address_enable = 1'b1;
        m.wide_address_select = 1'b1;
        m.region_zero.walk_off = 1'b1;
        m.region_one.walk_off = 1'b1;
        if (!eae) begin
            e.region_zero.walk_off = t[4];
            e.region_one.walk_off = t[5];
        end else begin
            e.region_zero.walk_off = t[7];
            e.region_one.walk_off = t[23];
            e.asid_source_select = t[22];
            e.region_zero.share = tcd_share_e'(t[13:12]);
            e.region_zero.outer = tcd_cache_e'(t[11:10]);
            e.region_zero.inner = tcd_cache_e'(t[9:8]);
            e.region_one.share = tcd_share_e'(t[29:28]);
            e.region_one.outer = tcd_cache_e'(t[27:26]);
            e.region_one.inner = tcd_cache_e'(t[25:24]);
            m.asid_source_select = 1'b1;
            m.region_zero.share = TCD_SH_INNER;
            m.region_zero.outer = TCD_C_WBNA;
            m.region_zero.inner = TCD_C_WBNA;
            m.region_one.share = TCD_SH_INNER;
            m.region_one.outer = TCD_C_WBNA;
            m.region_one.inner = TCD_C_WBNA;
            m.region_zero.size_offset = 6'h3f;
            m.region_one.size_offset = 6'h3f;
            rbm = 32'hffff_ffff;
            if (!c[0]) begin
                e.region_zero.nonsecure = c[3] & t[14];
                e.region_one.nonsecure = c[3] & t[30];
                m.region_zero.nonsecure = 1'b1;
                m.region_one.nonsecure = 1'b1;
                e.region_zero.size_offset = {3'h0, t[2:0]};
                e.region_one.size_offset = {3'h0, t[18:16]};
                rb = t & TCD_LONG_MASK;
            end else begin
                e.region_zero.size_offset = t[5:0];
                e.region_one.size_offset = t[21:16];
                m.region_zero.granule = 2'h3;
                m.region_one.granule = 2'h3;
                rb = t;
                case (t[15:14])
                    2'h0: e.region_zero.granule = TCD_GR_4K;
                    2'h1: e.region_zero.granule = TCD_GR_64K;
                    2'h2: e.region_zero.granule = TCD_GR_16K;
                    default: e.region_zero.granule = FB;
                endcase
                if (c[1] | c[2] | !c[5]) begin
                    e.region_one.granule = FB;
                end else begin
                    case (t[31:30])
                        2'h1: e.region_one.granule = TCD_GR_16K;
                        2'h2: e.region_one.granule = TCD_GR_4K;
                        2'h3: e.region_one.granule = TCD_GR_64K;
                        default: e.region_one.granule = FB;
                    endcase
                end
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // Drivers
    // ---------------------------------------------------------------
    // One bus access; waitrequest is read at the rising edge, before registers move
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_write <= wr;
        avs_read <= ~wr;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 64) begin
            error_cnt++;
            $display("BAD %0t bus access never answered", $time);
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m,
        input logic [1:0] r);
        rd_q.push_back('{d, m, r});
        bus(1'b0, a, 32'h0, 4'hf);
    endtask

    // A miss is either walked or faulted, one cycle later
    task automatic miss(input logic one, input logic off);
        walk_q.push_back({~off, off});
        @(posedge ref_clk);
        miss_valid <= 1'b1;
        miss_region_one <= one;
        @(posedge ref_clk);
        miss_valid <= 1'b0;
    endtask

    // Program bank and register, then probe walks, controls and readback
    task automatic apply(input logic [31:0] t, input logic [5:0] c);
        tcd_ctrl_s e;
        tcd_ctrl_s m;
        logic [31:0] rb;
        logic [31:0] rbm;
        model(t, c, e, m, rb, rbm);
        bus(1'b1, TCD_OFF_CFG, {26'h0, c}, 4'hf);
        bus(1'b1, TCD_OFF_CTRL, t, 4'hf);
        miss(1'b1, e.region_one.walk_off);
        miss(1'b0, e.region_zero.walk_off);
        ce_q.push_back(e);
        cm_q.push_back(m);
        @(posedge ref_clk);
        want_ctrl <= 1'b1;
        @(posedge ref_clk);
        want_ctrl <= 1'b0;
        rd(TCD_OFF_CTRL, rb, rbm, 2'h0);
        rd(TCD_OFF_CFG, {26'h0, c}, 32'h3f, 2'h0);
        rd(TCD_OFF_STAT, {29'h0, e.extended_address_enable, e.region_one.walk_off,
            e.region_zero.walk_off}, 32'h7, 2'h0);
    endtask

    // ---------------------------------------------------------------
    // Output monitor
    // ---------------------------------------------------------------
    // Sampled mid-cycle, where registered outputs have settled
    always @(negedge ref_clk) begin
        tcd_exp_rd_s x;
        logic [1:0] w;
        tcd_ctrl_s e;
        tcd_ctrl_s m;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (rd_q.size() > 0) begin
                x = rd_q.pop_front();
            end else begin
                x = '{32'h0, 32'h0, 2'bxx};
            end
            compares++;
            if (((avs_readdata & x.m) !== (x.d & x.m)) || (avs_response !== x.r)) begin
                error_cnt++;
                $display("BAD %0t read 0x%h exp 0x%h", $time, avs_readdata, x.d);
            end
        end
        if (walk_start === 1'b1 || walk_fault === 1'b1) begin
            w = (walk_q.size() > 0) ? walk_q.pop_front() : 2'bxx;
            compares++;
            if ({walk_start, walk_fault} !== w) begin
                error_cnt++;
                $display("BAD %0t walk outcome wrong", $time);
            end
        end
        if (want_ctrl === 1'b1) begin
            e = ce_q.pop_front();
            m = cm_q.pop_front();
            compares++;
            if ((ctrl & m) !== (e & m)) begin
                error_cnt++;
                $display("BAD %0t decoded controls 0x%h", $time, ctrl);
            end
        end
    end

    // ---------------------------------------------------------------
    // Closing and watchdog
    // ---------------------------------------------------------------
    task automatic results();
        if (rd_q.size() != 0 || walk_q.size() != 0) begin
            error_cnt++;
            $display("BAD %0t answers missing", $time);
        end
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // About 1050 cycles are expected; allow far more before giving up
    initial begin
        #80000;
        error_cnt++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end

    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        logic [2:0] jj;
        logic [3:0] kk;
        logic [31:0] t;
        logic [5:0] c;
        logic [5:0] cw[4];
        cw = '{6'h21, 6'h25, 6'h23, 6'h01};
        void'($urandom(97));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rd(TCD_OFF_CTRL, TCD_CTRL_RESET, 32'hffff_ffff, 2'h0);
        rd(TCD_OFF_CFG, TCD_CFG_RESET, 32'h3f, 2'h0);
        rd(TCD_OFF_STAT, 32'h0, 32'h7, 2'h0);
        // Unmapped and read-only places refuse writes
        rd(4'hc, 32'h0, 32'h0, 2'h3);
        bus(1'b1, 4'hc, 32'hffff_ffff, 4'hf);
        bus(1'b1, TCD_OFF_STAT, 32'hffff_ffff, 4'hf);
        rd(TCD_OFF_CTRL, 32'h0, 32'hffff_ffff, 2'h0);
        rd(TCD_OFF_STAT, 32'h0, 32'h7, 2'h0);
        // Long layout: every attribute code, secure and non-secure banks
        for (int j = 0; j < 8; j++) begin
            jj = 3'(j);
            t = {2'h3, jj[1:0], ~jj[1:0], jj[1:0], jj[0], jj[1], 3'h7, jj, 2'h3,
                jj[1:0], ~jj[1:0], jj[1:0], ~jj[0], 4'hf, ~jj};
            apply(t, {2'h2, jj[2], 3'h0});
        end
        // Byte lanes merge into the held value
        bus(1'b1, TCD_OFF_CTRL, 32'h8000_0000, 4'hf);
        bus(1'b1, TCD_OFF_CTRL, 32'hffff_ffff, 4'h2);
        rd(TCD_OFF_CTRL, 32'h8000_ff00 & TCD_LONG_MASK, 32'hffff_ffff, 2'h0);
        // Wide layout: every granule code in plain, monitor, hypervisor, non-stage-1 banks
        for (int k = 0; k < 16; k++) begin
            kk = 4'(k);
            t = $urandom;
            t[31:30] = kk[1:0];
            t[15:14] = kk[1:0];
            if (kk[3:2] == 2'h2) begin
                t[23] = 1'b0;
                t[7] = 1'b0;
            end
            apply(t, cw[kk[3:2]]);
        end
        // Short layout walk-off bits, long-layout bits void
        apply(32'h0080_0090, 6'h20);
        apply(32'h0000_00a0, 6'h20);
        // Extension forced by stage-2 and hypervisor banks
        apply(32'h0080_0000, 6'h30);
        apply(32'h0000_0030, 6'h22);
        // Random register and bank settings
        repeat (20) begin
            t = $urandom;
            c = 6'($urandom);
            if (c[1]) begin
                t[23] = 1'b0;
                t[7] = 1'b0;
            end
            apply(t, c);
        end
        results();
    end
endmodule // tb_top
